// >>> ssp_i2c.v
// i2c address match and master control of the sync serial port
//
// The register addresses and the APB slave port are this design's own decisions.
`include "ssp_map.vh"
module ssp_i2c #(
    parameter HALF_BIT = `SSP_HALF_BIT
) (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // i2c pins
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // interrupt
    output wire irq
);
    localparam ST_IDLE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_BIT = 3'd2;
    localparam ST_ACK = 3'd3;
    localparam ST_STOP = 3'd4;
    localparam ST_RSTART = 3'd5;
    reg [7:0] ctl1;
    reg [7:0] ctl2;
    reg [7:0] ctl3;
    reg [7:0] own_address_reg;
    reg [7:0] address_mask_reg;
    reg [7:0] port_data_buffer;
    reg [7:0] receive_shift_reg;
    reg [3:0] irq_stat;
    reg [3:0] irq_en;
    reg start_seen, stop_seen, update_address_flag, write_collision_flag, hold_scl;
    reg [3:0] bit_cnt;
    reg addr_phase, hi_byte_next, ack_drive, slave_active;
    reg [2:0] mst_state;
    reg [15:0] mst_cnt;
    reg [3:0] mst_bits;
    reg mst_phase, mst_scl_low, mst_sda_low, mst_rx;
    reg [7:0] mst_shift;
    wire scl_s, sda_s, start_det, stop_det, scl_rise, scl_fall;
    wire port_enable = ctl1[`SSP_CTL1_EN_BIT];
    wire [3:0] port_mode_select = ctl1[3:0];
    wire general_call_enable = ctl2[`SSP_CTL2_GENERAL_CALL_ENABLE_BIT];
    wire ack_value_select = ctl2[`SSP_CTL2_ACK_VALUE_SELECT_BIT];
    wire address_hold_enable = ctl3[`SSP_CTL3_ADDRESS_HOLD_ENABLE_BIT];
    wire is_master = port_enable && port_mode_select == `SSP_MODE_MASTER;
    wire is_fw = port_enable && port_mode_select == `SSP_MODE_FWMASTER;
    wire is_slave = port_enable && (port_mode_select == `SSP_MODE_SLAVE7 ||
        port_mode_select == `SSP_MODE_SLAVE10);
    wire ten_bit = port_mode_select == `SSP_MODE_SLAVE10;
    wire wr_acc = psel && penable && pwrite;
    wire mst_busy = mst_state != ST_IDLE;
    ssp_sync u_scl (.pclk(pclk), .presetn(presetn), .din(scl_in), .dout(scl_s));
    ssp_sync u_sda (.pclk(pclk), .presetn(presetn), .din(sda_in), .dout(sda_s));
    ssp_cond u_cond (.pclk(pclk), .presetn(presetn), .scl(scl_s), .sda(sda_s),
        .start_det(start_det), .stop_det(stop_det), .scl_rise(scl_rise),
        .scl_fall(scl_fall));
    wire [7:0] low_mask = ten_bit ? address_mask_reg : {address_mask_reg[7:1], 1'b0};
    wire low_match = ((receive_shift_reg ^ own_address_reg) & low_mask) == 8'h00;
    wire hi_match = receive_shift_reg[7:3] == 5'b11110 &&
        receive_shift_reg[2:1] == own_address_reg[2:1];
    wire gc_match = general_call_enable && receive_shift_reg == 8'h00;
    wire addr_match = gc_match || (hi_byte_next ? hi_match : low_match);
    wire ev_slave_byte = is_slave && scl_fall && bit_cnt == 4'd8 && slave_active;
    wire ev_gc = is_slave && scl_fall && bit_cnt == 4'd8 && addr_phase && gc_match;
    wire mst_done_start = mst_state == ST_START && mst_cnt == 16'd0 && mst_phase;
    wire mst_done_stop = mst_state == ST_STOP && mst_cnt == 16'd0 && mst_phase;
    wire mst_done_rs = mst_state == ST_RSTART && mst_cnt == 16'd0 && mst_phase;
    wire mst_done_byte = mst_state == ST_BIT && mst_cnt == 16'd0 && mst_phase &&
        mst_bits == 4'd7;
    wire mst_done_ack = mst_state == ST_ACK && mst_cnt == 16'd0 && mst_phase;
    wire cond_ev = (start_det || stop_det) && !is_master;
    wire flag_set = ev_slave_byte || ev_gc || (is_fw && cond_ev) ||
        mst_done_start || mst_done_stop || mst_done_rs || mst_done_byte ||
        mst_done_ack;
    wire write_collision_flag_set = wr_acc && paddr == `SSP_BUF_OFF && is_master &&
        mst_busy;
    wire [3:0] irq_set = {write_collision_flag_set, stop_det && !is_master,
        start_det && !is_master, flag_set};
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl1 <= 8'h00;
            ctl2 <= 8'h00;
            ctl3 <= 8'h00;
            own_address_reg <= 8'h00;
            address_mask_reg <= `SSP_MASK_RESET;
            irq_en <= 4'h0;
        end
        else
        begin
            if (wr_acc && paddr == `SSP_CTL1_OFF)
                ctl1 <= pwdata[7:0];
            if (wr_acc && paddr == `SSP_CTL2_OFF)
                ctl2 <= pwdata[7:0];
            else if (mst_done_start || mst_done_stop || mst_done_rs)
                ctl2[2:0] <= 3'b000;
            if (wr_acc && paddr == `SSP_CTL3_OFF)
                ctl3 <= pwdata[7:0];
            if (wr_acc && paddr == `SSP_OWNADDR_OFF)
                own_address_reg <= pwdata[7:0];
            if (wr_acc && paddr == `SSP_MASK_OFF)
                address_mask_reg <= pwdata[7:0];
            if (wr_acc && paddr == `SSP_IRQ_EN_OFF)
                irq_en <= pwdata[3:0];
        end
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= 4'h0;
        else if (wr_acc && paddr == `SSP_IRQ_CLR_OFF)
            irq_stat <= (irq_stat & ~pwdata[3:0]) | irq_set;
        else
            irq_stat <= irq_stat | irq_set;
    end
    assign irq = |(irq_stat & irq_en);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end
        else if (!port_enable || start_det || stop_det)
        begin
            start_seen <= port_enable && start_det;
            stop_seen <= port_enable && !start_det && stop_det;
        end
    end
    // slave receive, address match and clock hold
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            receive_shift_reg <= 8'h00;
            port_data_buffer <= 8'h00;
            bit_cnt <= 4'd0;
            addr_phase <= 1'b0;
            hi_byte_next <= 1'b0;
            slave_active <= 1'b0;
            update_address_flag <= 1'b0;
            ack_drive <= 1'b0;
            hold_scl <= 1'b0;
            write_collision_flag <= 1'b0;
        end
        else
        begin
            if (write_collision_flag_set)
                write_collision_flag <= 1'b1;
            else if (wr_acc && paddr == `SSP_STAT_OFF)
                write_collision_flag <= 1'b0;
            if (wr_acc && paddr == `SSP_BUF_OFF && !write_collision_flag_set)
                port_data_buffer <= pwdata[7:0];
            if (!is_slave || start_det || stop_det)
            begin
                bit_cnt <= 4'd0;
                addr_phase <= start_det;
                hi_byte_next <= start_det && ten_bit;
                slave_active <= 1'b0;
                ack_drive <= 1'b0;
                hold_scl <= 1'b0;
            end
            else
            begin
                if (wr_acc && paddr == `SSP_STAT_OFF)
                    update_address_flag <= 1'b0;
                if (scl_rise && bit_cnt < 4'd8)
                begin
                    receive_shift_reg <= {receive_shift_reg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'd1;
                end
                if (scl_fall && bit_cnt == 4'd8)
                begin
                    if (addr_phase && addr_match)
                    begin
                        port_data_buffer <= receive_shift_reg;
                        slave_active <= 1'b1;
                        ack_drive <= !address_hold_enable;
                        hold_scl <= address_hold_enable;
                        update_address_flag <= ten_bit && !gc_match;
                        hi_byte_next <= hi_byte_next && !gc_match && !receive_shift_reg[0];
                        addr_phase <= hi_byte_next && !gc_match && !receive_shift_reg[0];
                    end
                    else if (!addr_phase && slave_active)
                    begin
                        port_data_buffer <= receive_shift_reg;
                        ack_drive <= !ack_value_select;
                    end
                    bit_cnt <= 4'd9;
                end
                else if (scl_fall && bit_cnt == 4'd9 && !hold_scl)
                begin
                    ack_drive <= 1'b0;
                    bit_cnt <= 4'd0;
                end
                if (hold_scl && wr_acc && paddr == `SSP_CTL3_OFF && pwdata[0])
                begin
                    hold_scl <= 1'b0;
                    ack_drive <= !ack_value_select;
                end
            end
        end
    end
    // master sequencer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mst_state <= ST_IDLE;
            mst_cnt <= 16'd0;
            mst_phase <= 1'b0;
            mst_bits <= 4'd0;
            mst_scl_low <= 1'b0;
            mst_sda_low <= 1'b0;
            mst_shift <= 8'h00;
            mst_rx <= 1'b0;
        end
        else if (!is_master)
        begin
            mst_state <= ST_IDLE;
            mst_scl_low <= 1'b0;
            mst_sda_low <= 1'b0;
        end
        else if (mst_state == ST_IDLE)
        begin
            mst_cnt <= HALF_BIT[15:0];
            mst_phase <= 1'b0;
            if (ctl2[`SSP_CTL2_SEN_BIT])
                mst_state <= ST_START;
            else if (ctl2[`SSP_CTL2_RSEN_BIT])
                mst_state <= ST_RSTART;
            else if (ctl2[`SSP_CTL2_PEN_BIT])
                mst_state <= ST_STOP;
            else if (wr_acc && paddr == `SSP_BUF_OFF)
            begin
                mst_shift <= pwdata[7:0];
                mst_bits <= 4'd0;
                mst_rx <= 1'b0;
                mst_state <= ST_BIT;
            end
        end
        else if (mst_cnt != 16'd0)
            mst_cnt <= mst_cnt - 16'd1;
        else
        begin
            mst_cnt <= HALF_BIT[15:0];
            mst_phase <= !mst_phase;
            case (mst_state)
                ST_START, ST_RSTART:
                begin
                    if (!mst_phase)
                    begin
                        mst_scl_low <= 1'b0;
                        mst_sda_low <= mst_state == ST_START;
                    end
                    else
                    begin
                        mst_sda_low <= 1'b1;
                        mst_scl_low <= 1'b1;
                        mst_state <= ST_IDLE;
                    end
                end
                ST_BIT:
                begin
                    if (!mst_phase)
                    begin
                        mst_sda_low <= !mst_shift[7];
                        mst_scl_low <= 1'b0;
                    end
                    else
                    begin
                        mst_scl_low <= 1'b1;
                        mst_shift <= {mst_shift[6:0], sda_s};
                        mst_bits <= mst_bits + 4'd1;
                        if (mst_bits == 4'd7)
                            mst_state <= ST_ACK;
                    end
                end
                ST_ACK:
                begin
                    if (!mst_phase)
                    begin
                        mst_sda_low <= mst_rx && !ack_value_select;
                        mst_scl_low <= 1'b0;
                    end
                    else
                    begin
                        mst_scl_low <= 1'b1;
                        mst_state <= ST_IDLE;
                    end
                end
                ST_STOP:
                begin
                    if (!mst_phase)
                    begin
                        mst_sda_low <= 1'b1;
                        mst_scl_low <= 1'b0;
                    end
                    else
                    begin
                        mst_sda_low <= 1'b0;
                        mst_state <= ST_IDLE;
                    end
                end
                default:
                    mst_state <= ST_IDLE;
            endcase
        end
    end
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = (is_master && mst_scl_low) || (is_slave && hold_scl);
    assign sda_oe = (is_master && mst_sda_low) || (is_slave && ack_drive);
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `SSP_CTL1_OFF: prdata <= {24'h00_0000, ctl1};
                `SSP_CTL2_OFF: prdata <= {24'h00_0000, ctl2};
                `SSP_CTL3_OFF: prdata <= {24'h00_0000, ctl3};
                `SSP_OWNADDR_OFF: prdata <= {24'h00_0000, own_address_reg};
                `SSP_MASK_OFF: prdata <= {24'h00_0000, address_mask_reg};
                `SSP_BUF_OFF: prdata <= {24'h00_0000, port_data_buffer};
                `SSP_STAT_OFF: prdata <= {26'h000_0000, write_collision_flag,
                    update_address_flag, stop_seen, start_seen, hold_scl, mst_busy};
                `SSP_IRQ_STAT_OFF: prdata <= {28'h000_0000, irq_stat};
                `SSP_IRQ_EN_OFF: prdata <= {28'h000_0000, irq_en};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // ssp_i2c

// >>> ssp_map.vh
// register offsets, fields, reset values and timing counts
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
`define SSP_CTL1_OFF 12'h000
`define SSP_CTL2_OFF 12'h004
`define SSP_CTL3_OFF 12'h008
`define SSP_OWNADDR_OFF 12'h00C
`define SSP_MASK_OFF 12'h010
`define SSP_BUF_OFF 12'h014
`define SSP_STAT_OFF 12'h018
`define SSP_IRQ_STAT_OFF 12'h01C
`define SSP_IRQ_CLR_OFF 12'h020
`define SSP_IRQ_EN_OFF 12'h024
`define SSP_MASK_RESET 8'hff
`define SSP_MODE_SLAVE7 4'h6
`define SSP_MODE_SLAVE10 4'h7
`define SSP_MODE_MASTER 4'h8
`define SSP_MODE_FWMASTER 4'hb
`define SSP_CTL1_EN_BIT 5
`define SSP_CTL2_GENERAL_CALL_ENABLE_BIT 7
`define SSP_CTL2_ACK_VALUE_SELECT_BIT 5
`define SSP_CTL2_RSEN_BIT 1
`define SSP_CTL2_PEN_BIT 2
`define SSP_CTL2_SEN_BIT 0
`define SSP_CTL3_ADDRESS_HOLD_ENABLE_BIT 1
`define SSP_HALF_BIT 16'h0032
`endif

// >>> ssp_sync.v
// two-flop synchroniser for one pin level
module ssp_sync (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // level in and out
    input wire din,
    output reg dout
);
    reg meta;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= 1'b1;
            dout <= 1'b1;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // ssp_sync

// >>> ssp_cond.v
// start and stop condition detector on synchronised lines
module ssp_cond (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // synchronised lines
    input wire scl,
    input wire sda,
    // events
    output wire start_det,
    output wire stop_det,
    output wire scl_rise,
    output wire scl_fall
);
    reg scl_d;
    reg sda_d;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end
    assign start_det = scl & scl_d & sda_d & ~sda;
    assign stop_det = scl & scl_d & ~sda_d & sda;
    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
endmodule // ssp_cond

// >>> ssp_i2c_sva.sv
// port checker for the i2c port block
`include "ssp_map.vh"
module ssp_i2c_sva #(
    parameter HALF_BIT = `SSP_HALF_BIT
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins and interrupt
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire irq
);
    localparam int GEN_WAIT = 2 * HALF_BIT + 8;
    wire acc_wr = psel && penable && pwrite;
    wire acc_rd = psel && penable && !pwrite;
    reg mask_written;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // mask untouched since reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_written <= 1'b0;
        else if (acc_wr && paddr == `SSP_MASK_OFF)
            mask_written <= 1'b1;
    end
    sequence s_gen_start;
        $past(scl_in) && scl_in && $rose(sda_oe);
    endsequence
    sequence s_hold_release;
        acc_wr && paddr == `SSP_CTL3_OFF && pwdata[0] && scl_oe;
    endsequence
    AST_PINS_OD: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin data not low");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !presetn |-> !scl_oe && !sda_oe && !irq) else $error("active during reset");
    AST_MASK_RESET: assert property (acc_rd && paddr == `SSP_MASK_OFF && !mask_written
        |-> prdata[7:0] == `SSP_MASK_RESET) else $error("mask not all ones");
    AST_IRQ_STICKY: assert property ($fell(irq) |-> $past(acc_wr) &&
        $past(paddr) inside {`SSP_IRQ_CLR_OFF, `SSP_IRQ_EN_OFF, `SSP_CTL1_OFF})
        else $error("irq dropped by itself");
    AST_IRQ_MASKED: assert property (acc_wr && paddr == `SSP_IRQ_EN_OFF
        && pwdata[3:0] == 4'h0 |=> !irq) else $error("irq with enables clear");
    AST_START_CLOCK: assert property (s_gen_start |->
        sda_oe throughout (1'b1 ##[1:GEN_WAIT] scl_oe)) else $error("no clock after start");
    AST_HOLD_RELEASE: assert property (s_hold_release |-> ##[1:4] !scl_oe)
        else $error("held clock not released");
    AST_UNMAPPED_ZERO: assert property (acc_rd && paddr > `SSP_IRQ_EN_OFF |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_APB_READY: assert property (psel && penable |-> pready && !pslverr)
        else $error("access not ready");
endmodule // ssp_i2c_sva
bind ssp_i2c ssp_i2c_sva #(.HALF_BIT(HALF_BIT)) i_ssp_i2c_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// >>> ssp_bus_model.sv
// second i2c master on the shared two-wire bus
module ssp_bus_model (
    // wired bus levels
    input wire logic scl,
    input wire logic sda,
    // open-drain pulls
    output logic scl_oe,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // let scl go high, waiting out stretching
    task automatic rise();
        int n;
        n = 0;
        scl_oe = 1'b0;
        while (scl !== 1'b1 && n < 4000)
        begin
            #10;
            n++;
        end
    endtask
    // start, one byte msb first, acknowledge, stop
    task automatic frame(input logic [7:0] d, output logic ack);
        #7 sda_oe = 1'b1;
        #160 scl_oe = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            #80 sda_oe = !d[i];
            #80 rise();
            #160 scl_oe = 1'b1;
        end
        #80 sda_oe = 1'b0;
        #160 rise();
        #120 ack = !sda;
        #40 scl_oe = 1'b1;
        #80 sda_oe = 1'b1;
        #80 rise();
        #160 sda_oe = 1'b0;
        #160;
    endtask
endmodule // ssp_bus_model

// >>> tb.sv
// self-checking bench for the i2c port block
`include "ssp_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, ack;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [63:0] notes[$];
    logic [63:0] note;
    logic [7:0] own;
    logic [7:0] adr[4];
    logic [7:0] msk[4];
    logic exa[4];
    wire [31:0] prdata;
    wire pready, pslverr, scl_oe, sda_oe, irq, m_scl_oe, m_sda_oe;
    wire scl = !(scl_oe | m_scl_oe);
    wire sda = !(sda_oe | m_sda_oe);
    int miscompares, checked;
    ssp_i2c #(.HALF_BIT(4)) i_ssp_i2c (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq));
    ssp_bus_model i_ssp_bus_model (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checked++;
        if ((got & m) !== (exp & m))
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask
    task automatic stall();
        miscompares++;
        $display("ERROR %0t: wait ran out", $time);
        report_and_stop();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] m = 32'h0);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : 32'h0;
        if (!wr)
            notes.push_back({m, d});
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        if (n >= 64)
            stall();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // sel high: irq, low: clock pull
    task automatic wait_for(input logic sel);
        int n;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while ((sel ? irq : scl_oe) !== 1'b1 && n < 3000);
        if (n >= 3000)
            stall();
        @(posedge pclk);
    endtask
    task automatic chk(input logic sel, input logic e);
        @(negedge pclk);
        cmp({31'h0, sel ? irq : scl_oe}, {31'h0, e}, 32'h1);
        @(posedge pclk);
    endtask
    task automatic xfer(input logic [7:0] d, input logic e);
        i_ssp_bus_model.frame(d, ack);
        @(posedge pclk);
        cmp({31'h0, ack}, {31'h0, e}, 32'h1);
    endtask
    // read results against the oldest note
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1)
        begin
            note = notes.pop_front();
            cmp(prdata, note[31:0], note[63:32]);
        end
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        miscompares = 0;
        checked = 0;
        own = 8'($urandom(32'hbe89));
        own = {1'b1, own[6:1], 1'b0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `SSP_MASK_OFF, 32'hff, 32'hff);
        apb(0, `SSP_STAT_OFF, 32'h0, 32'h3f);
        apb(1, 12'h100, 32'hffff_ffff);
        apb(0, 12'h100, 32'h0, 32'hffff_ffff);
        apb(1, `SSP_CTL1_OFF, 32'h26);
        apb(1, `SSP_OWNADDR_OFF, {24'h0, own});
        adr = '{own, own ^ 8'h06, own ^ 8'h06, own ^ 8'h0a};
        msk = '{8'hff, 8'hff, 8'hf9, 8'hf9};
        exa = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `SSP_MASK_OFF, {24'h0, msk[i]});
            xfer(adr[i], exa[i]);
        end
        apb(0, `SSP_STAT_OFF, 32'h8, 32'h8);
        apb(1, `SSP_CTL1_OFF, 32'h06);
        apb(0, `SSP_STAT_OFF, 32'h0, 32'hc);
        apb(1, `SSP_CTL1_OFF, 32'h26);
        apb(1, `SSP_MASK_OFF, 32'hff);
        xfer(8'h00, 1'b0);
        apb(1, `SSP_CTL2_OFF, 32'h80);
        apb(1, `SSP_IRQ_CLR_OFF, 32'hf);
        xfer(8'h00, 1'b1);
        apb(0, `SSP_IRQ_STAT_OFF, 32'h1, 32'h1);
        chk(1'b1, 1'b0);
        apb(1, `SSP_IRQ_EN_OFF, 32'h1);
        chk(1'b1, 1'b1);
        apb(1, `SSP_IRQ_CLR_OFF, 32'hf);
        chk(1'b1, 1'b0);
        apb(1, `SSP_IRQ_EN_OFF, 32'h0);
        apb(1, `SSP_CTL1_OFF, 32'h27);
        xfer(8'h00, 1'b1);
        apb(0, `SSP_STAT_OFF, 32'h0, 32'h10);
        apb(1, `SSP_CTL1_OFF, 32'h26);
        apb(1, `SSP_CTL2_OFF, 32'h0);
        apb(1, `SSP_CTL3_OFF, 32'h2);
        fork
            xfer(own, 1'b1);
            begin
                wait_for(1'b0);
                repeat (20) @(posedge pclk);
                chk(1'b0, 1'b1);
                apb(1, `SSP_CTL3_OFF, 32'h3);
            end
        join
        apb(1, `SSP_CTL3_OFF, 32'h0);
        apb(1, `SSP_IRQ_CLR_OFF, 32'hf);
        apb(1, `SSP_IRQ_EN_OFF, 32'h1);
        apb(1, `SSP_CTL1_OFF, 32'h28);
        apb(1, `SSP_CTL2_OFF, 32'h1);
        apb(1, `SSP_BUF_OFF, $urandom() & 32'hff);
        wait_for(1'b1);
        apb(0, `SSP_CTL2_OFF, 32'h0, 32'h1);
        apb(0, `SSP_IRQ_STAT_OFF, 32'h9, 32'hf);
        apb(0, `SSP_STAT_OFF, 32'h20, 32'h20);
        apb(1, `SSP_STAT_OFF, 32'h0);
        apb(0, `SSP_STAT_OFF, 32'h0, 32'h20);
        apb(1, `SSP_IRQ_CLR_OFF, 32'hf);
        chk(1'b1, 1'b0);
        apb(1, `SSP_BUF_OFF, {24'h0, own});
        wait_for(1'b1);
        apb(0, `SSP_STAT_OFF, 32'h1, 32'h1);
        apb(1, `SSP_IRQ_CLR_OFF, 32'hf);
        wait_for(1'b1);
        apb(0, `SSP_STAT_OFF, 32'h0, 32'h1);
        apb(1, `SSP_IRQ_CLR_OFF, 32'hf);
        apb(1, `SSP_CTL2_OFF, 32'h4);
        wait_for(1'b1);
        apb(0, `SSP_CTL2_OFF, 32'h0, 32'h4);
        apb(0, `SSP_IRQ_STAT_OFF, 32'h1, 32'hf);
        apb(1, `SSP_IRQ_CLR_OFF, 32'hf);
        apb(1, `SSP_CTL1_OFF, 32'h2b);
        xfer(own, 1'b0);
        apb(0, `SSP_IRQ_STAT_OFF, 32'h6, 32'h6);
        apb(1, `SSP_IRQ_EN_OFF, 32'h0);
        report_and_stop();
    end
endmodule // tb
